// >>> core/ialc_pkg.sv
// Purpose: Shared constants and types of the interlock teach and lock control
// Assumes: 50 MHz system clock, plain register port with 4-bit byte address
// Notes:   Long intervals are held here in their own units and as cycle counts
package ialc_pkg;
    localparam longint unsigned CLK_HZ         = 50_000_000;
    localparam longint unsigned TEACH_SHOW_S   = 10;
    localparam longint unsigned OFF_REQ_MIN    = 5;
    localparam longint unsigned INHIBIT_MIN    = 10;
    localparam longint unsigned SLOW_FLASH_HZ  = 1;
    localparam longint unsigned FAST_FLASH_HZ  = 3;
    localparam longint unsigned TEACH_CYC      = TEACH_SHOW_S * CLK_HZ;
    localparam longint unsigned OFF_REQ_CYC    = OFF_REQ_MIN * 60 * CLK_HZ;
    localparam longint unsigned INHIBIT_CYC    = INHIBIT_MIN * 60 * CLK_HZ;
    localparam longint unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_FLASH_HZ);
    localparam longint unsigned FAST_HALF_CYC  = CLK_HZ / (2 * FAST_FLASH_HZ);
    localparam int              FAULT_PULSES   = 5;
    localparam int              TW             = 36;
    localparam int              CODE_W         = 16;
    // Arbitrary value standing for the factory standard actuator code
    localparam logic [15:0]     STD_CODE       = 16'h5A5A;

    localparam logic [3:0]      ADDR_CTRL      = 4'h0;
    localparam logic [3:0]      ADDR_STATUS    = 4'h4;
    localparam logic [3:0]      ADDR_IRQ_STAT  = 4'h8;
    localparam logic [3:0]      ADDR_IRQ_MASK  = 4'hC;
    localparam logic [3:0]      CTRL_RESET     = 4'h0;
    localparam logic [3:0]      MASK_RESET     = 4'h0;
    localparam int              IRQ_TEACH      = 0;
    localparam int              IRQ_ABORT      = 1;
    localparam int              IRQ_STORED     = 2;
    localparam int              IRQ_RELEASED   = 3;

    // Bit 0 individual coding, 1 re-teachable, 2 power-to-lock, 3 door-open outputs
    typedef struct packed {
        logic doorOpenVariant;
        logic powerToLock;
        logic reteachableVariant;
        logic individualCoding;
    } ialc_ctrl_t;

    typedef struct packed {
        logic green;
        logic red;
        logic yellow;
    } ialc_led_t;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_RUN     = 3'b001,
        ST_TEACH   = 3'b011,
        ST_REQOFF  = 3'b010,
        ST_CONFIRM = 3'b110,
        ST_INHIBIT = 3'b111,
        ST_FAULT   = 3'b101
    } ialc_state_t;

    function automatic logic ialc_hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction : ialc_hit
endpackage : ialc_pkg

// >>> core/ialc_ctrl.sv
// Purpose: Teach-in, enabling inhibit, lock drive and safety output control
// Assumes: supplyOn models the operating voltage; stored code survives its loss
// Notes:   Notes on behaviour below; rst stands for the factory state
`timescale 1ns/1ps
`default_nettype none
module ialc_ctrl
    import ialc_pkg::*;
#(
    parameter longint unsigned TEACH_CYC_P   = TEACH_CYC,
    parameter longint unsigned OFF_REQ_CYC_P = OFF_REQ_CYC,
    parameter longint unsigned INHIBIT_CYC_P = INHIBIT_CYC,
    parameter longint unsigned SLOW_HALF_P   = SLOW_HALF_CYC,
    parameter longint unsigned FAST_HALF_P   = FAST_HALF_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [3:0]        regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdData,
    output logic                   irq,
    input  wire logic              supplyOn,
    input  wire logic              actuatorPresent,
    input  wire logic [CODE_W-1:0] actuatorCode,
    input  wire logic              lockCmd,
    input  wire logic              safety_input_first,
    input  wire logic              safety_input_second,
    output logic                   lockEngaged,
    output logic                   safety_output_first,
    output logic                   safety_output_second,
    output ialc_led_t              led
);
    localparam logic [TW-1:0] TEACH_END   = TW'(TEACH_CYC_P - 1);
    localparam logic [TW-1:0] OFF_REQ_END = TW'(OFF_REQ_CYC_P - 1);
    localparam logic [TW-1:0] INHIB_END   = TW'(INHIBIT_CYC_P - 1);
    localparam logic [TW-1:0] SLOW_END    = TW'(SLOW_HALF_P - 1);
    localparam logic [TW-1:0] FAST_END    = TW'(FAST_HALF_P - 1);
    localparam logic [3:0]    FAULT_EDGES = 4'(2 * FAULT_PULSES);

    ialc_ctrl_t          ctrl_q;
    logic [3:0]          irqMask_q;
    logic [3:0]          irqStat_q;
    logic [3:0]          irqEvt;
    ialc_state_t         state_q;
    ialc_state_t         state_d;
    logic                supplyPrev_q;
    logic [TW-1:0]       timer_q;
    logic [TW-1:0]       slowCnt_q;
    logic [TW-1:0]       fastCnt_q;
    logic                slowPhase_q;
    logic                fastPhase_q;
    logic [3:0]          faultEdges_q;
    logic [CODE_W-1:0]   storedCode_q;
    logic                codeValid_q;
    logic                learnedOnce_q;
    logic [CODE_W-1:0]   teachCode_q;
    logic [CODE_W-1:0]   pendingCode_q;
    logic                pendingValid_q;
    logic                inhibitPending_q;
    logic                teachArmed_q;
    logic                powerUp;
    logic                codeMatch;
    logic                mayTeach;
    logic                lockNow;
    logic                outEnable;
    logic                slowTick;
    logic                fastTick;

    assign powerUp = supplyOn & ~supplyPrev_q;
    assign slowTick = slowCnt_q == SLOW_END;
    assign fastTick = fastCnt_q == FAST_END;

    // True in the cycle in which the machine leaves one state for another
    function automatic logic step(input ialc_state_t src, input ialc_state_t dst);
        return state_q == src && state_d == dst;
    endfunction : step

    always_comb begin
        if (ctrl_q.individualCoding) begin
            codeMatch = codeValid_q && actuatorCode == storedCode_q;
        end else begin
            codeMatch = actuatorCode == STD_CODE;
        end
    end

    // One-time units refuse once paired; re-teachable ones accept again whenever teaching is armed
    assign mayTeach = ctrl_q.individualCoding & teachArmed_q
                    & (ctrl_q.reteachableVariant | ~learnedOnce_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (powerUp) begin
                    if (pendingValid_q) begin
                        state_d = ST_CONFIRM;
                    end else if (inhibitPending_q) begin
                        state_d = ST_INHIBIT;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (actuatorPresent && !codeMatch && mayTeach) begin
                    state_d = ST_TEACH;
                end
            end
            ST_TEACH: begin
                if (!actuatorPresent) begin
                    state_d = ST_RUN;
                end else if (timer_q == TEACH_END) begin
                    state_d = ST_REQOFF;
                end
            end
            ST_REQOFF: begin
                if (timer_q == OFF_REQ_END) begin
                    state_d = ST_FAULT;
                end
            end
            ST_CONFIRM: begin
                if (actuatorPresent && actuatorCode == pendingCode_q) begin
                    state_d = ST_INHIBIT;
                end
            end
            ST_INHIBIT: begin
                if (timer_q == INHIB_END && actuatorPresent && codeMatch) begin
                    state_d = ST_RUN;
                end
            end
            ST_FAULT: begin
                state_d = ST_FAULT;
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!supplyOn) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q      <= ST_OFF;
            supplyPrev_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            supplyPrev_q <= supplyOn;
        end
    end

    // Holds at the inhibit end, so the teach and off-request counts must stay below it
    // Saturating interval timer, restarted on each state change and power-up
    always_ff @(posedge sys_clk) begin
        if (rst || !supplyOn || state_d != state_q) begin
            timer_q <= '0;
        end else if (timer_q != INHIB_END && timer_q != '1) begin
            timer_q <= timer_q + TW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !supplyOn) begin
            slowCnt_q   <= '0;
            fastCnt_q   <= '0;
            slowPhase_q <= 1'b0;
            fastPhase_q <= 1'b0;
        end else begin
            slowCnt_q   <= slowTick ? '0 : slowCnt_q + TW'(1);
            fastCnt_q   <= fastTick ? '0 : fastCnt_q + TW'(1);
            slowPhase_q <= slowPhase_q ^ slowTick;
            fastPhase_q <= fastPhase_q ^ fastTick;
        end
    end

    // Count half periods of the slow flash to give exactly five red pulses
    always_ff @(posedge sys_clk) begin
        if (rst || state_q != ST_FAULT) begin
            faultEdges_q <= '0;
        end else if (slowTick && faultEdges_q != FAULT_EDGES) begin
            faultEdges_q <= faultEdges_q + 4'h1;
        end
    end

    // Pairing memory; only rst clears it, supply loss does not
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            storedCode_q     <= '0;
            codeValid_q      <= 1'b0;
            learnedOnce_q    <= 1'b0;
            teachCode_q      <= '0;
            pendingCode_q    <= '0;
            pendingValid_q   <= 1'b0;
            inhibitPending_q <= 1'b0;
        end else begin
            if (state_q == ST_RUN && state_d == ST_TEACH) begin
                teachCode_q <= actuatorCode;
            end
            if (state_q == ST_TEACH && state_d == ST_REQOFF) begin
                pendingCode_q  <= teachCode_q;
                pendingValid_q <= 1'b1;
            end
            if (state_q == ST_REQOFF && state_d == ST_FAULT) begin
                pendingValid_q <= 1'b0;
            end
            if (state_q == ST_CONFIRM && state_d == ST_INHIBIT) begin
                storedCode_q     <= pendingCode_q;
                codeValid_q      <= 1'b1;
                learnedOnce_q    <= 1'b1;
                pendingValid_q   <= 1'b0;
                inhibitPending_q <= 1'b1;
            end
            if (state_q == ST_INHIBIT && state_d == ST_RUN) begin
                inhibitPending_q <= 1'b0;
            end
        end
    end

    // Teaching is only offered to the first actuator seen after a power-up
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            teachArmed_q <= 1'b0;
        end else if (powerUp) begin
            teachArmed_q <= 1'b1;
        end else if (state_q == ST_RUN && actuatorPresent) begin
            teachArmed_q <= 1'b0;
        end
    end

    assign lockNow = ctrl_q.powerToLock ? lockCmd : ~lockCmd;

    always_comb begin
        outEnable = state_q == ST_RUN && supplyOn && actuatorPresent && codeMatch
                    && safety_input_first && safety_input_second;
        if (!ctrl_q.doorOpenVariant) begin
            outEnable = outEnable && lockNow;
        end
    end
    // In the door-open variant releasing the lock does not drop the outputs; the actuator leaving does

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lockEngaged          <= 1'b0;
            safety_output_first  <= 1'b0;
            safety_output_second <= 1'b0;
        end else begin
            lockEngaged          <= supplyOn & lockNow;
            safety_output_first  <= outEnable;
            safety_output_second <= outEnable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led <= '0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    led <= '0;
                end
                ST_TEACH: begin
                    led <= '{green: 1'b0, red: 1'b1, yellow: slowPhase_q};
                end
                ST_REQOFF: begin
                    led <= '{green: 1'b0, red: 1'b1, yellow: fastPhase_q};
                end
                ST_CONFIRM: begin
                    led <= '{green: 1'b0, red: 1'b1, yellow: 1'b0};
                end
                ST_INHIBIT: begin
                    led <= '{green: slowPhase_q, red: 1'b0, yellow: 1'b0};
                end
                ST_FAULT: begin
                    led <= '{green: 1'b1, red: faultEdges_q[0],
                             yellow: 1'b0};
                end
                default: begin
                    led <= '{green: 1'b1, red: 1'b0,
                             yellow: actuatorPresent & (lockNow | slowPhase_q)};
                end
            endcase
        end
    end

    // Software hears about the transitions of the teach sequence only
    always_comb begin
        irqEvt = '0;
        irqEvt[IRQ_TEACH]    = step(ST_RUN, ST_TEACH);
        irqEvt[IRQ_ABORT]    = step(ST_REQOFF, ST_FAULT);
        irqEvt[IRQ_STORED]   = step(ST_CONFIRM, ST_INHIBIT);
        irqEvt[IRQ_RELEASED] = step(ST_INHIBIT, ST_RUN);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q    <= CTRL_RESET;
            irqMask_q <= MASK_RESET;
        end else if (regWr) begin
            if (ialc_hit(regAddr, ADDR_CTRL)) begin
                ctrl_q <= regWrData[3:0];
            end
            if (ialc_hit(regAddr, ADDR_IRQ_MASK)) begin
                irqMask_q <= regWrData[3:0];
            end
        end
    end

    // A new event in the clearing cycle wins over the write-one clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqStat_q <= '0;
        end else if (regWr && ialc_hit(regAddr, ADDR_IRQ_STAT)) begin
            irqStat_q <= (irqStat_q & ~regWrData[3:0]) | irqEvt;
        end else begin
            irqStat_q <= irqStat_q | irqEvt;
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            case (regAddr)
                ADDR_CTRL: begin
                    regRdData <= {28'h0000000, ctrl_q};
                end
                ADDR_STATUS: begin
                    regRdData <= {20'h00000, inhibitPending_q, pendingValid_q,
                                  learnedOnce_q, codeValid_q, lockEngaged,
                                  safety_output_first, led, state_q};
                end
                ADDR_IRQ_STAT: begin
                    regRdData <= {28'h0000000, irqStat_q};
                end
                ADDR_IRQ_MASK: begin
                    regRdData <= {28'h0000000, irqMask_q};
                end
                default: begin
                    regRdData <= '0;
                end
            endcase
        end else begin
            regRdData <= '0;
        end
    end
endmodule : ialc_ctrl
`default_nettype wire

// >>> verification/ialc_ctrl_asserts.sv
// Purpose: Port checker of the interlock teach and lock control
// Assumes: CTRL and IRQ_MASK change only through writes seen at the ports
// Notes:   Variant bits are shadowed from bus writes so the checker needs no internals
`timescale 1ns/1ps
`default_nettype none
module ialc_ctrl_asserts
    import ialc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        irq,
    input wire logic        supplyOn,
    input wire logic        actuatorPresent,
    input wire logic        lockCmd,
    input wire logic        safety_input_first,
    input wire logic        safety_input_second,
    input wire logic        lockEngaged,
    input wire logic        safety_output_first,
    input wire logic        safety_output_second
);
    ialc_ctrl_t ctrl_q;
    logic [3:0] mask_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            mask_q <= MASK_RESET;
        end else if (regWr && regAddr == ADDR_CTRL) begin
            ctrl_q <= regWrData[3:0];
        end else if (regWr && regAddr == ADDR_IRQ_MASK) begin
            mask_q <= regWrData[3:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_rd_quiet;
        !$past(regRd) |-> regRdData == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside its slot");
    property p_irq_masked;
        mask_q == 4'h0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all events masked");
    property p_unlock_cmd;
        lockCmd && !ctrl_q.powerToLock |=> !lockEngaged;
    endproperty
    a_unlock_cmd: assert property (p_unlock_cmd) else $error("locked while asked to unlock");
    property p_lock_cmd;
        !lockCmd && ctrl_q.powerToLock |=> !lockEngaged;
    endproperty
    a_lock_cmd: assert property (p_lock_cmd) else $error("locked without lock command");
    property p_std_release;
        !ctrl_q.doorOpenVariant && !$past(ctrl_q.doorOpenVariant) && safety_output_first
            |-> lockEngaged;
    endproperty
    a_std_release: assert property (p_std_release) else $error("outputs on while unlocked");
    property p_door_open;
        !actuatorPresent |=> !safety_output_first;
    endproperty
    a_door_open: assert property (p_door_open) else $error("outputs on with guard open");
    property p_door_keep;
        ctrl_q.doorOpenVariant && $past(ctrl_q.doorOpenVariant) && $past(safety_output_first)
            && $past(actuatorPresent && supplyOn && safety_input_first && safety_input_second)
            |-> safety_output_first;
    endproperty
    a_door_keep: assert property (p_door_keep) else $error("outputs dropped, guard closed");
    property p_pair;
        safety_output_first == safety_output_second;
    endproperty
    a_pair: assert property (p_pair) else $error("safety outputs disagree");
    property p_chain;
        !(safety_input_first && safety_input_second) || !supplyOn |=> !safety_output_first;
    endproperty
    a_chain: assert property (p_chain) else $error("outputs on without supply or chain");
endmodule : ialc_ctrl_asserts

bind ialc_ctrl ialc_ctrl_asserts u_chk (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .supplyOn(supplyOn),
    .actuatorPresent(actuatorPresent), .lockCmd(lockCmd),
    .safety_input_first(safety_input_first), .safety_input_second(safety_input_second),
    .lockEngaged(lockEngaged), .safety_output_first(safety_output_first),
    .safety_output_second(safety_output_second)
);
`default_nettype wire

// >>> verification/ialc_actuator_model.sv
// Purpose: Door actuator model facing the interlock
// Assumes: Bench asks for insertion and a code by level
// Notes:   Code lines carry a moving pattern while no actuator is in range
`timescale 1ns/1ps
`default_nettype none
module ialc_actuator_model
    import ialc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              insertReq,
    input  wire logic [CODE_W-1:0] codeReq,
    output logic                   actuatorPresent,
    output logic      [CODE_W-1:0] actuatorCode
);
    initial actuatorCode = 16'h0;
    always @(posedge sys_clk) begin
        actuatorPresent <= insertReq;
        // Out of range the code is never valid, so the old value must not linger
        actuatorCode    <= insertReq ? codeReq : ~actuatorCode;
    end
endmodule : ialc_actuator_model
`default_nettype wire

// >>> verification/interlock_actuator_teach_lock_ctrl_tb.sv
// Purpose: Self-checking bench of the interlock teach and lock control
// Assumes: Shortened interval parameters, one 50 MHz clock
// Notes:   Waits poll STATUS over the register port with bounded counts
`timescale 1ns/1ps
`default_nettype none
module interlock_actuator_teach_lock_ctrl_tb;
    import ialc_pkg::*;
    localparam int TC = 100;
    localparam int OC = 200;
    localparam int IC = 300;
    logic              sys_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0]        regAddr = 4'h0;
    logic [31:0]       regWrData = 32'h0, regRdData, rv, rnd;
    logic              irq, supplyOn = 1'b0, lockCmd = 1'b0, sIn = 1'b0, insertReq = 1'b0;
    logic              actuatorPresent, lockEngaged, outA, outB, redLast = 1'b0, grnLast = 1'b0;
    logic              ylwLast = 1'b0;
    int                ylwFlips = 0;
    logic [CODE_W-1:0] actuatorCode, codeReq = 16'h0, cA, cB, cD;
    ialc_led_t         led;
    int                err_total = 0, n_checks = 0, cyc = 0, redRises = 0, grnFlips = 0, t0;
    integer            seed = 32'hfdeb2621;

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc      <= cyc + 1;
        redLast  <= led.red;
        grnLast  <= led.green;
        ylwLast  <= led.yellow;
        if (led.yellow !== ylwLast) ylwFlips <= ylwFlips + 1;
        if (led.red && !redLast) redRises <= redRises + 1;
        if (led.green !== grnLast) grnFlips <= grnFlips + 1;
    end

    ialc_ctrl #(.TEACH_CYC_P(TC), .OFF_REQ_CYC_P(OC), .INHIBIT_CYC_P(IC), .SLOW_HALF_P(5),
        .FAST_HALF_P(3)) dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
        .supplyOn(supplyOn), .actuatorPresent(actuatorPresent), .actuatorCode(actuatorCode),
        .lockCmd(lockCmd), .safety_input_first(sIn), .safety_input_second(sIn),
        .lockEngaged(lockEngaged), .safety_output_first(outA), .safety_output_second(outB),
        .led(led));
    ialc_actuator_model far (.sys_clk(sys_clk), .insertReq(insertReq), .codeReq(codeReq),
        .actuatorPresent(actuatorPresent), .actuatorCode(actuatorCode));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge sys_clk);
        regWr     <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1 rv = regRdData;
    endtask : rd

    task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
        rd(a);
        chk(what, e, rv & m);
    endtask : rchk

    task automatic wait_st(input logic [31:0] m, input logic [31:0] v, input int lim);
        int k;
        rd(ADDR_STATUS);
        for (k = 0; k < lim && (rv & m) !== v; k++) begin
            rd(ADDR_STATUS);
        end
        chk("status", v, rv & m);
        if ((rv & m) !== v) complete_run();
    endtask : wait_st

    task automatic put(input logic ins, input logic [CODE_W-1:0] c);
        @(posedge sys_clk);
        insertReq <= ins;
        codeReq   <= c;
        repeat (3) @(posedge sys_clk);
    endtask : put

    // Counts yellow changes over 30 settled cycles of a steady flash
    task automatic flash_chk(input string what, input int exp);
        int f;
        repeat (2) @(posedge sys_clk);
        f = ylwFlips;
        repeat (30) @(posedge sys_clk);
        chk(what, exp, ylwFlips - f);
    endtask : flash_chk

    task automatic power_cycle;
        @(posedge sys_clk) supplyOn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        supplyOn <= 1'b1;
    endtask : power_cycle

    task automatic fresh(input logic [CODE_W-1:0] c);
        put(1'b0, c);
        power_cycle();
        put(1'b1, c);
    endtask : fresh

    task automatic teach_start(input logic [CODE_W-1:0] c);
        fresh(c);
        wait_st(32'h7, ST_TEACH, 10);
        chk("learn leds", 2'b01, {led.green, led.red});
        flash_chk("slow yellow", 6);
        wait_st(32'h7, ST_REQOFF, TC);
        flash_chk("fast yellow", 10);
    endtask : teach_start

    task automatic teach_end(input bit cut);
        int gf;
        power_cycle();
        wait_st(32'h47, ST_INHIBIT, 10);
        t0 = cyc;
        gf = grnFlips;
        if (cut) begin
            repeat (IC / 2) @(posedge sys_clk);
            // A power dip mid-inhibit must not shorten the remaining wait
            power_cycle();
            t0 = cyc;
        end
        wait_st(32'h47, 32'h41, IC);
        chk("inhibit span", 1'b1, cyc - t0 >= IC - 6 && cyc - t0 <= IC + 12);
        chk("green flashing", 1'b1, grnFlips - gf >= 10);
    endtask : teach_end

    initial begin
        rnd = $random(seed);
        cA = {rnd[15:2], 2'b01};
        cB = cA ^ 16'h0010;
        cD = cA ^ 16'h0100;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(ADDR_CTRL, 32'hF, CTRL_RESET, "ctrl reset");
        rchk(ADDR_IRQ_MASK, 32'hF, MASK_RESET, "mask reset");
        wr(4'h2, rnd);
        rchk(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
        rnd = $random(seed);
        wr(ADDR_CTRL, rnd);
        rchk(ADDR_CTRL, 32'hF, rnd & 32'hF, "ctrl");
        wr(ADDR_CTRL, 32'h0);
        $display("test registers done");
        @(posedge sys_clk);
        supplyOn <= 1'b1;
        sIn      <= 1'b1;
        put(1'b1, STD_CODE);
        wait_st(32'hC0, 32'hC0, 20);
        @(posedge sys_clk) lockCmd <= 1'b1;
        wait_st(32'hC0, 32'h0, 5);
        @(posedge sys_clk) lockCmd <= 1'b0;
        wait_st(32'hC0, 32'hC0, 5);
        wr(ADDR_CTRL, 32'h8);
        @(posedge sys_clk) lockCmd <= 1'b1;
        wait_st(32'hC0, 32'h40, 5);
        put(1'b0, STD_CODE);
        wait_st(32'h40, 32'h0, 5);
        wr(ADDR_CTRL, 32'h4);
        put(1'b1, STD_CODE);
        wait_st(32'hC0, 32'hC0, 10);
        @(posedge sys_clk) lockCmd <= 1'b0;
        wait_st(32'h80, 32'h0, 5);
        wr(ADDR_CTRL, 32'h0);
        put(1'b0, cA);
        put(1'b1, cA);
        repeat (10) @(posedge sys_clk);
        rchk(ADDR_STATUS, 32'h47, ST_RUN, "foreign actuator");
        $display("test standard done");
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_IRQ_STAT, 32'hF);
        wr(ADDR_IRQ_MASK, 32'hF);
        teach_start(cA);
        rchk(ADDR_IRQ_STAT, 32'hF, 32'h1, "teach event");
        chk("irq raised", 1'b1, irq);
        wr(ADDR_IRQ_MASK, 32'h0);
        chk("irq masked", 1'b0, irq);
        wr(ADDR_IRQ_MASK, 32'hF);
        wr(ADDR_IRQ_STAT, 32'h1);
        chk("irq cleared", 1'b0, irq);
        teach_end(1'b1);
        rchk(ADDR_IRQ_STAT, 32'hC, 32'hC, "stored and released");
        teach_start(cB);
        teach_end(1'b0);
        put(1'b0, cA);
        put(1'b1, cA);
        repeat (10) @(posedge sys_clk);
        rchk(ADDR_STATUS, 32'h40, 32'h0, "old actuator");
        put(1'b0, cB);
        put(1'b1, cB);
        wait_st(32'h40, 32'h40, 10);
        $display("test teach done");
        teach_start(cD);
        t0 = redRises;
        wait_st(32'h7, ST_FAULT, OC);
        repeat (120) @(posedge sys_clk);
        chk("red pulses", FAULT_PULSES, redRises - t0);
        rchk(ADDR_IRQ_STAT, 32'h2, 32'h2, "abort event");
        $display("test abort done");
        wr(ADDR_CTRL, 32'h1);
        fresh(cD);
        repeat (10) @(posedge sys_clk);
        rchk(ADDR_STATUS, 32'h47, ST_RUN, "one time refusal");
        put(1'b0, cB);
        put(1'b1, cB);
        wait_st(32'h40, 32'h40, 10);
        $display("test one time done");
        complete_run();
    end
endmodule : interlock_actuator_teach_lock_ctrl_tb
`default_nettype wire
